// ==== swlsp_slave.sv ====
// What this block does
// - Eight scratchpad bytes, positions zero to seven, read in order.
// - Bytes zero and one carry temperature, low byte first.
// - Bytes two and three copy the stored triggers, reloaded at reset.
// - Bytes four and five always read as all ones.
// - Bytes six and seven hold residual count and counts per degree.
// - Ninth byte is the CRC of the eight scratchpad bytes.
// - Trigger writes land in scratchpad; only copy moves them to storage.
// - Data pin only pulls low or releases; line is wired AND.
// - Line low more than 480 us resets the link state.
// - Order: init, identity command, memory command, then data.
// - Init is master reset pulse then slave presence pulse.
// - After presence, exactly one 8-bit identity command follows.
// - Identity read sends family code, 48-bit serial and CRC.
// - Identity match answers memory command only on full 64-bit match.
// - A mismatched device ignores the bus until the next reset.
// - Identity skip goes straight to memory command.
// - Identity search joins the bitwise elimination process.
// - Alarm search joins elimination only when alarm flag is set.
// - Alarm set when temperature above high or below low stored trigger.
// - Alarm flag holds until a measurement falls within limits.
// - Search sends bit, complement, then drops out on differing write.
// - After reset rise wait 15-60 us, then drive low 60-240 us.
// - Compare 8-bit triggers with temperature minus its half-degree bit.
// - CRC: zeroed shift register, LSB first, X^8+X^5+X^4+1.
`timescale 1ns/1ps
module swlsp_slave
  import swlsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe,
  input wire swlsp_meas_type meas,
  input wire logic meas_done,
  input wire logic convert_busy,
  input wire logic [7:0] nv_high_trigger,
  input wire logic [7:0] nv_low_trigger,
  input wire logic nv_busy,
  output logic convert_start,
  output logic nv_write,
  output logic [7:0] nv_write_high,
  output logic [7:0] nv_write_low,
  output logic alarm_flag
);

  // ****************************************************************
  // Identity and scratchpad images
  // ****************************************************************
  localparam logic [55:0] ID_BODY = {SERIAL_NUMBER, FAMILY_CODE};
  localparam logic [7:0] ID_CRC = swlsp_crc8({8'h00, ID_BODY}, 56);
  localparam logic [63:0] IDENTITY = {ID_CRC, ID_BODY};

  swlsp_state_type state;
  swlsp_stat_type status_sel;
  logic line;
  logic fall;
  logic us_tick;
  logic long_low;
  logic long_rise;
  logic [7:0] high_alarm_trigger;
  logic [7:0] low_alarm_trigger;
  logic load_pending;
  logic [7:0] pres_us;
  logic slot_active;
  logic [5:0] slot_us;
  logic slot_done;
  logic [6:0] bit_cnt;
  logic [1:0] phase;
  logic mismatch;
  logic [7:0] shift_sr;
  logic [7:0] next_byte;
  logic [63:0] pad_body;
  logic [71:0] pad_image;
  logic tx_mode;
  logic tx_bit;
  logic next_drive;
  logic id_bit;
  logic [7:0] rx_cmd;
  logic [6:0] temp_whole;

  swlsp_line u_line (
    .clk(clk),
    .rst(rst),
    .dq_in(dq_in),
    .line(line),
    .fall(fall),
    .us_tick(us_tick),
    .long_low(long_low),
    .long_rise(long_rise)
  );

  // Scratchpad bytes in read order
  assign pad_body = {meas.per_degree, meas.residual,
                     PAD_FILL, PAD_FILL,
                     low_alarm_trigger, high_alarm_trigger,
                     meas.temperature};
  // Check byte follows as the ninth byte
  assign pad_image = {swlsp_crc8(pad_body, 64), pad_body};

  // ****************************************************************
  // Slot timing
  // ****************************************************************
  // A slot opens on a master falling edge and closes at the sample point
  assign slot_done = slot_active & us_tick
                     & (slot_us == SLOT_SAMPLE_US - 6'd1);

  always_ff @(posedge clk)
  begin
    if (rst || long_low)
    begin
      slot_active <= 1'b0;
      slot_us <= 6'h00;
    end
    else if (slot_done)
      slot_active <= 1'b0;
    else if (!slot_active && fall && state >= ST_ROM_CMD)
    begin
      // Any high gap before the edge is fine
      slot_active <= 1'b1;
      slot_us <= 6'h00;
    end
    else if (slot_active && us_tick)
      slot_us <= slot_us + 6'h01;
  end

  // ****************************************************************
  // Transmit bit selection
  // ****************************************************************
  assign id_bit = IDENTITY[bit_cnt[5:0]];
  assign rx_cmd = {line, shift_sr[7:1]};
  assign next_byte = {line, shift_sr[7:1]};

  // Bit the device places on the line in a read slot
  always_comb
  begin
    tx_mode = 1'b0;
    tx_bit = 1'b1;
    unique case (state)
      ST_ROM_READ:
      begin
        tx_mode = 1'b1;
        tx_bit = id_bit;
      end
      ST_SEARCH:
      begin
        tx_mode = (phase != 2'h2);
        tx_bit = (phase == 2'h0) ? id_bit : ~id_bit;
      end
      ST_PAD_READ:
      begin
        tx_mode = 1'b1;
        tx_bit = pad_image[bit_cnt];
      end
      ST_STATUS:
      begin
        tx_mode = 1'b1;
        if (status_sel == STAT_CONVERT)
          tx_bit = ~convert_busy;
        else if (status_sel == STAT_COPY)
          tx_bit = ~nv_busy;
        else
          tx_bit = 1'b1;
      end
      default:
      begin
        tx_mode = 1'b0;
        tx_bit = 1'b1;
      end
    endcase
  end

  // Pull low for presence or a zero; otherwise release
  assign next_drive = (state == ST_PRES_LOW)
                      | (slot_active & tx_mode & ~tx_bit);

  // ****************************************************************
  // Pin driver
  // ****************************************************************
  // Only ever pulls low; the pull-up makes the high level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dq_out <= 1'b0;
      dq_oe <= 1'b0;
    end
    else
    begin
      dq_out <= 1'b0;
      dq_oe <= next_drive;
    end
  end

  // ****************************************************************
  // Transaction sequencer
  // ****************************************************************
  // A long low wins over everything but rst, so a stuck bus never hangs us
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= ST_WAIT_RESET;
      status_sel <= STAT_DONE;
      pres_us <= 8'h00;
      bit_cnt <= 7'h00;
      phase <= 2'h0;
      mismatch <= 1'b0;
      shift_sr <= 8'h00;
    end
    else if (long_low)
      state <= ST_WAIT_RESET;
    else if (long_rise)
    begin
      state <= ST_PRES_WAIT;
      pres_us <= 8'h00;
    end
    else
    begin
      unique case (state)
        ST_WAIT_RESET:
          pres_us <= 8'h00;
        ST_PRES_WAIT:
          if (us_tick)
          begin
            pres_us <= pres_us + 8'h01;
            if (pres_us == PRESENCE_WAIT_US - 8'h01)
            begin
              state <= ST_PRES_LOW;
              pres_us <= 8'h00;
            end
          end
        ST_PRES_LOW:
          if (us_tick)
          begin
            pres_us <= pres_us + 8'h01;
            if (pres_us == PRESENCE_LOW_US - 8'h01)
            begin
              state <= ST_ROM_CMD;
              bit_cnt <= 7'h00;
            end
          end
        ST_ROM_CMD:
          if (slot_done)
          begin
            shift_sr <= next_byte;
            bit_cnt <= bit_cnt + 7'h01;
            if (bit_cnt == BYTE_LAST)
            begin
              bit_cnt <= 7'h00;
              phase <= 2'h0;
              mismatch <= 1'b0;
              if (rx_cmd == CMD_ID_READ)
                state <= ST_ROM_READ;
              else if (rx_cmd == CMD_ID_MATCH)
                state <= ST_ROM_MATCH;
              else if (rx_cmd == CMD_ID_SKIP)
                state <= ST_FUNC_CMD;
              else if (rx_cmd == CMD_ID_SEARCH)
                state <= ST_SEARCH;
              else if (rx_cmd == CMD_ALARM_SEARCH)
                state <= alarm_flag ? ST_SEARCH : ST_WAIT_RESET;
              else
                state <= ST_WAIT_RESET;
            end
          end
        ST_ROM_READ:
          if (slot_done)
          begin
            bit_cnt <= bit_cnt + 7'h01;
            if (bit_cnt == ID_LAST)
            begin
              state <= ST_FUNC_CMD;
              bit_cnt <= 7'h00;
            end
          end
        ST_ROM_MATCH:
          if (slot_done)
          begin
            bit_cnt <= bit_cnt + 7'h01;
            if (line != id_bit)
              mismatch <= 1'b1;
            if (bit_cnt == ID_LAST)
            begin
              bit_cnt <= 7'h00;
              if (mismatch || line != id_bit)
                state <= ST_WAIT_RESET;
              else
                state <= ST_FUNC_CMD;
            end
          end
        ST_SEARCH:
          if (slot_done)
          begin
            if (phase != 2'h2)
              phase <= phase + 2'h1;
            else if (line != id_bit)
              state <= ST_WAIT_RESET;
            else
            begin
              phase <= 2'h0;
              bit_cnt <= bit_cnt + 7'h01;
              if (bit_cnt == ID_LAST)
              begin
                state <= ST_FUNC_CMD;
                bit_cnt <= 7'h00;
              end
            end
          end
        ST_FUNC_CMD:
          if (slot_done)
          begin
            shift_sr <= next_byte;
            bit_cnt <= bit_cnt + 7'h01;
            if (bit_cnt == BYTE_LAST)
            begin
              bit_cnt <= 7'h00;
              // Memory command only reached through an identity command
              if (rx_cmd == CMD_PAD_WRITE)
                state <= ST_PAD_WRITE;
              else if (rx_cmd == CMD_PAD_READ)
                state <= ST_PAD_READ;
              else if (rx_cmd == CMD_PAD_COPY)
              begin
                state <= ST_STATUS;
                status_sel <= STAT_COPY;
              end
              else if (rx_cmd == CMD_CONVERT)
              begin
                state <= ST_STATUS;
                status_sel <= STAT_CONVERT;
              end
              else if (rx_cmd == CMD_RECALL)
              begin
                state <= ST_STATUS;
                status_sel <= STAT_DONE;
              end
              else
                state <= ST_WAIT_RESET;
            end
          end
        ST_PAD_WRITE:
          if (slot_done)
          begin
            shift_sr <= next_byte;
            bit_cnt <= bit_cnt + 7'h01;
            if (bit_cnt == WORD_LAST)
              state <= ST_WAIT_RESET;
          end
        ST_PAD_READ:
          if (slot_done)
          begin
            bit_cnt <= bit_cnt + 7'h01;
            if (bit_cnt == PAD_LAST)
              state <= ST_WAIT_RESET;
          end
        ST_STATUS:
          bit_cnt <= 7'h00;
        default:
          state <= ST_WAIT_RESET;
      endcase
    end
  end

  // ****************************************************************
  // Scratchpad triggers
  // ****************************************************************
  // Stored values are caught one cycle after reset, never under it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      load_pending <= 1'b1;
      high_alarm_trigger <= 8'h00;
      low_alarm_trigger <= 8'h00;
    end
    else if (load_pending)
    begin
      load_pending <= 1'b0;
      high_alarm_trigger <= nv_high_trigger;
      low_alarm_trigger <= nv_low_trigger;
    end
    else if (!long_low && state == ST_PAD_WRITE && slot_done)
    begin
      // Master writes only reach the scratchpad copy
      if (bit_cnt == BYTE_LAST)
        high_alarm_trigger <= next_byte;
      else if (bit_cnt == WORD_LAST)
        low_alarm_trigger <= next_byte;
    end
    else if (!long_low && state == ST_FUNC_CMD && slot_done
             && bit_cnt == BYTE_LAST && rx_cmd == CMD_RECALL)
    begin
      high_alarm_trigger <= nv_high_trigger;
      low_alarm_trigger <= nv_low_trigger;
    end
  end

  // ****************************************************************
  // Command side effects
  // ****************************************************************
  // One-cycle strobes to the storage and the converter
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      convert_start <= 1'b0;
      nv_write <= 1'b0;
      nv_write_high <= 8'h00;
      nv_write_low <= 8'h00;
    end
    else
    begin
      convert_start <= 1'b0;
      nv_write <= 1'b0;
      if (!long_low && state == ST_FUNC_CMD && slot_done
          && bit_cnt == BYTE_LAST)
      begin
        convert_start <= (rx_cmd == CMD_CONVERT);
        if (rx_cmd == CMD_PAD_COPY)
        begin
          nv_write <= 1'b1;
          nv_write_high <= high_alarm_trigger;
          nv_write_low <= low_alarm_trigger;
        end
      end
    end
  end

  // ****************************************************************
  // Alarm qualification
  // ****************************************************************
  // Half-degree bit dropped; sign sits in the trigger's top bit
  assign temp_whole = meas.temperature[7:1];

  // Stored triggers are used, so unsaved edits need a copy first
  always_ff @(posedge clk)
  begin
    if (rst)
      alarm_flag <= 1'b0;
    else if (meas_done)
      alarm_flag <= ($signed({meas.temperature[15], temp_whole})
                     > $signed(nv_high_trigger))
                    | ($signed({meas.temperature[15], temp_whole})
                       < $signed(nv_low_trigger));
  end

endmodule : swlsp_slave

// ==== swlsp_pkg.sv ====
package swlsp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int US_CYCLES = CLK_HZ / 1_000_000;
  localparam logic [4:0] US_LAST = 5'(US_CYCLES - 1);
  // Longer than this low time resets the link
  localparam logic [8:0] RESET_LOW_US = 9'd480;
  // Presence wait 15-60 us, presence low 60-240 us
  localparam logic [7:0] PRESENCE_WAIT_US = 8'd30;
  localparam logic [7:0] PRESENCE_LOW_US = 8'd120;
  // Slot sample point; a zero we send is held until here
  localparam logic [5:0] SLOT_SAMPLE_US = 6'd30;

  // ****************************************************************
  // Commands
  // ****************************************************************
  localparam logic [7:0] CMD_ID_READ = 8'h33;
  localparam logic [7:0] CMD_ID_MATCH = 8'h55;
  localparam logic [7:0] CMD_ID_SKIP = 8'hcc;
  localparam logic [7:0] CMD_ID_SEARCH = 8'hf0;
  localparam logic [7:0] CMD_ALARM_SEARCH = 8'hec;
  localparam logic [7:0] CMD_PAD_WRITE = 8'h4e;
  localparam logic [7:0] CMD_PAD_READ = 8'hbe;
  localparam logic [7:0] CMD_PAD_COPY = 8'h48;
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_RECALL = 8'hb8;

  // ****************************************************************
  // Scratchpad layout and identity
  // ****************************************************************
  localparam logic [3:0] PAD_TEMP_LO = 4'h0;
  localparam logic [3:0] PAD_TEMP_HI = 4'h1;
  localparam logic [3:0] PAD_HIGH_TRIG = 4'h2;
  localparam logic [3:0] PAD_LOW_TRIG = 4'h3;
  localparam logic [3:0] PAD_UNUSED_A = 4'h4;
  localparam logic [3:0] PAD_UNUSED_B = 4'h5;
  localparam logic [3:0] PAD_RESIDUAL = 4'h6;
  localparam logic [3:0] PAD_PER_DEGREE = 4'h7;
  localparam logic [3:0] PAD_CHECK = 4'h8;
  localparam logic [7:0] PAD_FILL = 8'hff;
  localparam logic [6:0] BYTE_LAST = 7'd7;
  localparam logic [6:0] WORD_LAST = 7'd15;
  localparam logic [6:0] ID_LAST = 7'd63;
  localparam logic [6:0] PAD_LAST = 7'd71;
  localparam logic [7:0] CRC_POLY_REFLECTED = 8'h8c;
  // Arbitrary family and serial values
  localparam logic [7:0] FAMILY_CODE = 8'h7e;
  localparam logic [47:0] SERIAL_NUMBER = 48'h0000_0000_0001;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [15:0] temperature;
    logic [7:0] residual;
    logic [7:0] per_degree;
  } swlsp_meas_type;

  typedef enum logic [3:0] {
    ST_WAIT_RESET = 4'h0,
    ST_PRES_WAIT = 4'h1,
    ST_PRES_LOW = 4'h2,
    ST_ROM_CMD = 4'h3,
    ST_ROM_READ = 4'h4,
    ST_ROM_MATCH = 4'h5,
    ST_SEARCH = 4'h6,
    ST_FUNC_CMD = 4'h7,
    ST_PAD_WRITE = 4'h8,
    ST_PAD_READ = 4'h9,
    ST_STATUS = 4'ha
  } swlsp_state_type;

  typedef enum logic [1:0] {
    STAT_CONVERT = 2'h0,
    STAT_COPY = 2'h1,
    STAT_DONE = 2'h2
  } swlsp_stat_type;

  // Serial CRC, cleared to zero, fed least significant bit first
  function automatic logic [7:0] swlsp_crc8(input logic [63:0] data,
                                            input int nbits);
    logic [7:0] crc;
    logic fb;
    crc = 8'h00;
    for (int i = 0; i < 64; i++)
    begin
      if (i < nbits)
      begin
        fb = crc[0] ^ data[i];
        crc = crc >> 1;
        if (fb)
          crc = crc ^ CRC_POLY_REFLECTED;
      end
    end
    return crc;
  endfunction : swlsp_crc8

endpackage : swlsp_pkg

// ==== swlsp_line.sv ====
`timescale 1ns/1ps
module swlsp_line
  import swlsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic dq_in,
  output logic line,
  output logic fall,
  output logic us_tick,
  output logic long_low,
  output logic long_rise
);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic [4:0] div_count;
  logic [8:0] low_us;
  logic long_seen;

  // Three stages; level moves only when last two agree
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      sync_c <= 1'b1;
    end
    else
    begin
      sync_a <= dq_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Filtered level and falling edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      line <= 1'b1;
      fall <= 1'b0;
    end
    else
    begin
      fall <= 1'b0;
      if (sync_b == sync_c)
      begin
        line <= sync_c;
        fall <= line & ~sync_c;
      end
    end
  end

  // ****************************************************************
  // Microsecond enable
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_count <= 5'h00;
      us_tick <= 1'b0;
    end
    else
    begin
      us_tick <= (div_count == US_LAST);
      div_count <= (div_count == US_LAST) ? 5'h00 : div_count + 5'h01;
    end
  end

  // ****************************************************************
  // Long low detection
  // ****************************************************************
  // Counter saturates so an endless low reports once
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      low_us <= 9'h000;
      long_low <= 1'b0;
      long_seen <= 1'b0;
      long_rise <= 1'b0;
    end
    else
    begin
      long_low <= 1'b0;
      long_rise <= 1'b0;
      if (line)
      begin
        low_us <= 9'h000;
        long_seen <= 1'b0;
        long_rise <= long_seen;
      end
      else if (us_tick && low_us <= RESET_LOW_US)
      begin
        low_us <= low_us + 9'h001;
        if (low_us == RESET_LOW_US)
        begin
          long_low <= 1'b1;
          long_seen <= 1'b1;
        end
      end
    end
  end

endmodule : swlsp_line

// ==== swlsp_slave_monitor.sv ====
`timescale 1ns/1ps
// ****
// Link checker
// ****
module swlsp_slave_monitor
  import swlsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe,
  input wire swlsp_meas_type meas,
  input wire logic meas_done,
  input wire logic [7:0] nv_high_trigger,
  input wire logic [7:0] nv_low_trigger,
  input wire logic convert_start,
  input wire logic alarm_flag
);
  logic [12:0] oe_cnt;
  logic [13:0] low_cnt;
  logic [10:0] hi_cnt;
  logic [7:0] deg;
  logic hot;
  // Half-degree bit dropped, sign kept on top
  assign deg = {meas.temperature[15], meas.temperature[7:1]};
  assign hot = $signed(deg) > $signed(nv_high_trigger)
    || $signed(deg) < $signed(nv_low_trigger);
  // Length of the device pull, saturating
  always_ff @(posedge clk)
    if (rst || !dq_oe)
      oe_cnt <= '0;
    else if (oe_cnt != '1)
      oe_cnt <= oe_cnt + 1'b1;
  // Length of a low line
  always_ff @(posedge clk)
    if (rst || dq_in)
      low_cnt <= '0;
    else if (low_cnt != '1)
      low_cnt <= low_cnt + 1'b1;
  // Length of a high line; saturates so a pull after a long idle stays out of window
  always_ff @(posedge clk)
    if (rst || !dq_in)
      hi_cnt <= '0;
    else if (hi_cnt != '1)
      hi_cnt <= hi_cnt + 1'b1;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_start_pulse;
    convert_start ##1 !convert_start;
  endsequence
  chk_pull_only: assert property (dq_oe |-> !dq_out)
    else $error("line driven high");
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !dq_oe && !alarm_flag && !convert_start)
    else $error("outputs busy after reset");
  chk_long_low: assert property (low_cnt > 14'd9620 |-> !dq_oe)
    else $error("pull during long low");
  chk_pres_delay: assert property ($rose(dq_oe) |->
    hi_cnt == '0 || hi_cnt inside {[11'd300:11'd1220]})
    else $error("presence start out of window");
  chk_pull_len: assert property ($fell(dq_oe) |->
    oe_cnt <= 13'd620 || oe_cnt inside {[13'd1200:13'd4800]})
    else $error("pull length out of window");
  chk_alarm_set: assert property (meas_done |=>
    alarm_flag == $past(hot))
    else $error("alarm flag wrong");
  chk_alarm_hold: assert property (!meas_done |=> $stable(alarm_flag))
    else $error("alarm flag moved");
  chk_start_pulse: assert property (convert_start |-> s_start_pulse)
    else $error("start not one cycle");
endmodule : swlsp_slave_monitor

bind swlsp_slave swlsp_slave_monitor mon (.clk(clk), .rst(rst),
  .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .meas(meas),
  .meas_done(meas_done), .nv_high_trigger(nv_high_trigger),
  .nv_low_trigger(nv_low_trigger), .convert_start(convert_start),
  .alarm_flag(alarm_flag));

// ==== swlsp_master.sv ====
`timescale 1ns/1ps
// ****
// Bus master model
// ****
module swlsp_master
  import swlsp_pkg::*;
(
  input wire logic clk,
  input wire logic line,
  output logic pull
);
  // Released, so the pull-up holds the line high between bits
  initial pull = 1'b0;
  // Wait whole cycles, then step off the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : hold
  // Long low, release, then sample the presence answer
  task automatic bus_reset(output logic seen);
    pull = 1'b1;
    hold(9700);
    pull = 1'b0;
    hold(1800);
    seen = !line;
    hold(1300);
  endtask : bus_reset
  // Short low reads or writes a one, long low writes a zero
  task automatic slot(input logic b, output logic got);
    pull = 1'b1;
    hold(b ? 20 : 620);
    pull = 1'b0;
    hold(b ? 280 : 20);
    got = line;
    if (b)
      hold(340);
  endtask : slot
  // Whole byte, least significant bit first
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 0; i < 8; i++)
      slot(tx[i], rx[i]);
  endtask : xfer
endmodule : swlsp_master

// ==== tb.sv ====
`timescale 1ns/1ps
// ****
// Bench
// ****
module tb
  import swlsp_pkg::*;
;
  // Stored triggers never change, so no reconversion is ever owed
  localparam logic [7:0] NV_HI = 8'h19;
  localparam logic [7:0] NV_LO = 8'h05;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pull;
  logic dq_out;
  logic dq_oe;
  logic line;
  swlsp_meas_type meas = '{16'h0032, 8'h0c, 8'h10};
  logic meas_done = 1'b0;
  logic convert_start;
  logic alarm_flag;
  int n_errors = 0;
  int checks = 0;
  int starts = 0;
  // Open-drain wire with pull-up; a single slave, so reads never collide
  assign line = !(pull || dq_oe);
  always #25 clk = ~clk;
  // Count conversion requests
  always @(posedge clk)
    if (convert_start === 1'b1)
      starts++;
  swlsp_master m (.clk(clk), .line(line), .pull(pull));
  swlsp_slave dut (
    .clk(clk), .rst(rst), .dq_in(line), .dq_out(dq_out), .dq_oe(dq_oe),
    .meas(meas), .meas_done(meas_done), .convert_busy(1'b0),
    .nv_high_trigger(NV_HI), .nv_low_trigger(NV_LO), .nv_busy(1'b0),
    .convert_start(convert_start), .nv_write(), .nv_write_high(),
    .nv_write_low(), .alarm_flag(alarm_flag));
  task automatic cmp8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8
  task automatic cmp1(input string what, input logic exp, input logic got);
    cmp8(what, {7'h00, exp}, {7'h00, got});
  endtask : cmp1
  // Reference check byte, kept apart from the design's own
  function automatic logic [7:0] crc_of(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 64; i++)
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
    return c;
  endfunction : crc_of
  // Above, inside, below, inside the stored limits
  task automatic t_alarm;
    logic [15:0] temps [4] = '{16'h0034, 16'h0032, 16'h0008, 16'h0032};
    logic [3:0] want = 4'b0101;
    for (int i = 0; i < 4; i++)
    begin
      meas.temperature = temps[i];
      meas_done = 1'b1;
      m.hold(1);
      meas_done = 1'b0;
      m.hold(3);
      cmp1("alarm flag", want[i], alarm_flag);
    end
  endtask : t_alarm
  // Skip, then the whole scratchpad and its check byte
  task automatic t_pad_read;
    logic seen;
    logic [7:0] rx;
    logic [63:0] pad;
    pad = {8'h10, 8'h0c, 8'hff, 8'hff, NV_LO, NV_HI, 8'h00, 8'h32};
    m.bus_reset(seen);
    cmp1("presence", 1'b1, seen);
    m.xfer(CMD_ID_SKIP, rx);
    m.xfer(CMD_PAD_READ, rx);
    for (int i = 0; i < 8; i++)
    begin
      m.xfer(8'hff, rx);
      cmp8("pad byte", pad[8*i +: 8], rx);
    end
    m.xfer(8'hff, rx);
    cmp8("check byte", crc_of(pad), rx);
  endtask : t_pad_read
  // Unknown identity code must leave the device silent
  task automatic t_unknown;
    logic seen;
    logic [7:0] rx;
    m.bus_reset(seen);
    cmp1("presence", 1'b1, seen);
    m.xfer(8'h00, rx);
    m.xfer(CMD_PAD_READ, rx);
    m.xfer(8'hff, rx);
    cmp8("muted byte", 8'hff, rx);
  endtask : t_unknown
  // Skip then convert gives exactly one start
  task automatic t_convert;
    logic seen;
    logic [7:0] rx;
    starts = 0;
    m.bus_reset(seen);
    m.xfer(CMD_ID_SKIP, rx);
    m.xfer(CMD_CONVERT, rx);
    m.hold(40);
    cmp8("convert starts", 8'h01, 8'(starts));
  endtask : t_convert
  task automatic finish_test;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    #5;
    rst = 1'b0;
    t_alarm();
    t_pad_read();
    t_unknown();
    t_convert();
    finish_test();
  end
  // Watchdog for a hung link; the tests need about 6.0 ms of traffic
  initial
  begin
    #6_500_000;
    n_errors++;
    finish_test();
  end
endmodule : tb
